/* File: mrid_move_exec.v */
// Execution of the move-register-to-destination instruction over four phases
`include "mrid_defs.vh"
module mrid_move_exec #(
    parameter AW = 12
) (
    input  wire          clk,
    input  wire          rst,
    input  wire [15:0]   instrWord,
    input  wire          instrValid,
    input  wire [3:0]    bankSelect,
    input  wire          extEnable,
    input  wire [AW-1:0] indexBase,
    input  wire [7:0]    memRdata,
    input  wire [7:0]    statusIn,
    output wire [1:0]    phase,
    output wire          busy,
    output wire [AW-1:0] memAddr,
    output wire          memRd,
    output wire          memWr,
    output wire [7:0]    memWdata,
    output wire          accWr,
    output wire [7:0]    accWdata,
    output wire          statusWr,
    output wire [7:0]    statusOut,
    output wire          indexedUsed,
    output wire          illegal,
    output wire          done
);
    // ==========================================
    // Phase codes
    localparam [1:0] PH_DECODE  = `MRID_Q1;
    localparam [1:0] PH_READ    = `MRID_Q2;
    localparam [1:0] PH_PROCESS = `MRID_Q3;
    localparam [1:0] PH_WRITE   = `MRID_Q4;

    // ==========================================
    // Registers and their next values
    reg           active_r;
    reg           active_nxt;
    reg  [1:0]    phase_r;
    reg  [1:0]    phase_nxt;
    reg  [15:0]   instr_r;
    reg  [15:0]   instr_nxt;
    reg  [7:0]    data_r;
    reg  [7:0]    data_nxt;
    reg  [1:0]    phaseOut_r;
    reg  [1:0]    phaseOut_nxt;
    reg  [AW-1:0] memAddr_r;
    reg  [AW-1:0] memAddr_nxt;
    reg           memRd_r;
    reg           memRd_nxt;
    reg           memWr_r;
    reg           memWr_nxt;
    reg  [7:0]    memWdata_r;
    reg  [7:0]    memWdata_nxt;
    reg           accWr_r;
    reg           accWr_nxt;
    reg  [7:0]    accWdata_r;
    reg  [7:0]    accWdata_nxt;
    reg           statusWr_r;
    reg           statusWr_nxt;
    reg  [7:0]    statusOut_r;
    reg  [7:0]    statusOut_nxt;
    reg           indexedUsed_r;
    reg           indexedUsed_nxt;
    reg           illegal_r;
    reg           illegal_nxt;
    reg           done_r;
    reg           done_nxt;

    // ==========================================
    // Instruction fields
    wire [AW-1:0] resAddr;
    wire          resIdx;
    wire          isMove;
    wire          destSel;
    wire          accSel;
    wire [7:0]    opAddr;
    assign isMove  = (instrWord[`MRID_OPC_HI:`MRID_OPC_LO] == `MRID_OPC_VAL);
    assign destSel = instr_r[`MRID_DEST_BIT];
    assign accSel  = instr_r[`MRID_ACC_BIT];
    assign opAddr  = instr_r[`MRID_ADDR_HI:`MRID_ADDR_LO];

    // ==========================================
    // Operand address
    mrid_addr_resolve #(.AW(AW)) uResolve (
        .operandAddr (opAddr),
        .accessSel   (accSel),
        .bankSelect  (bankSelect),
        .extEnable   (extEnable),
        .indexBase   (indexBase),
        .fullAddr    (resAddr),
        .indexedMode (resIdx)
    );

    // ==========================================
    // Sequencer next state
    always @* begin
        // Strobes default low so a write can never repeat
        active_nxt      = active_r;
        phase_nxt       = phase_r;
        instr_nxt       = instr_r;
        data_nxt        = data_r;
        phaseOut_nxt    = phase_r;
        memAddr_nxt     = memAddr_r;
        memRd_nxt       = 1'b0;
        memWr_nxt       = 1'b0;
        memWdata_nxt    = memWdata_r;
        accWr_nxt       = 1'b0;
        accWdata_nxt    = accWdata_r;
        statusWr_nxt    = 1'b0;
        statusOut_nxt   = statusOut_r;
        indexedUsed_nxt = indexedUsed_r;
        illegal_nxt     = 1'b0;
        done_nxt        = 1'b0;
        case (phase_r)
            PH_DECODE: begin
                // Foreign opcodes are flagged, not executed
                if (instrValid && !active_r) begin
                    if (isMove) begin
                        instr_nxt  = instrWord;
                        active_nxt = 1'b1;
                        phase_nxt  = PH_READ;
                    end else begin
                        illegal_nxt = 1'b1;
                    end
                end
            end
            PH_READ: begin
                memAddr_nxt     = resAddr;
                indexedUsed_nxt = resIdx;
                memRd_nxt       = 1'b1;
                phase_nxt       = PH_PROCESS;
            end
            PH_PROCESS: begin
                // Memory answers one edge after the read strobe
                data_nxt  = memRdata;
                phase_nxt = PH_WRITE;
            end
            PH_WRITE: begin
                if (destSel) begin
                    memWr_nxt    = 1'b1;
                    memWdata_nxt = data_r;
                end else begin
                    accWr_nxt    = 1'b1;
                    accWdata_nxt = data_r;
                end
                // Other flags pass through untouched
                statusWr_nxt                = 1'b1;
                statusOut_nxt               = statusIn;
                statusOut_nxt[`MRID_FLAG_Z] = (data_r == `MRID_ZERO_BYTE);
                statusOut_nxt[`MRID_FLAG_N] = data_r[`MRID_SIGN_BIT];
                done_nxt                    = 1'b1;
                active_nxt                  = 1'b0;
                phase_nxt                   = PH_DECODE;
            end
            default: begin
                active_nxt = 1'b0;
                phase_nxt  = PH_DECODE;
            end
        endcase
    end

    // ==========================================
    // Sequencer registers
    always @(posedge clk) begin
        if (rst) begin
            active_r      <= 1'b0;
            phase_r       <= PH_DECODE;
            instr_r       <= `MRID_RST_WORD;
            data_r        <= `MRID_RST_BYTE;
            phaseOut_r    <= PH_DECODE;
            memAddr_r     <= {AW{1'b0}};
            memRd_r       <= 1'b0;
            memWr_r       <= 1'b0;
            memWdata_r    <= `MRID_RST_BYTE;
            accWr_r       <= 1'b0;
            accWdata_r    <= `MRID_RST_BYTE;
            statusWr_r    <= 1'b0;
            statusOut_r   <= `MRID_RST_BYTE;
            indexedUsed_r <= 1'b0;
            illegal_r     <= 1'b0;
            done_r        <= 1'b0;
        end else begin
            active_r      <= active_nxt;
            phase_r       <= phase_nxt;
            instr_r       <= instr_nxt;
            data_r        <= data_nxt;
            phaseOut_r    <= phaseOut_nxt;
            memAddr_r     <= memAddr_nxt;
            memRd_r       <= memRd_nxt;
            memWr_r       <= memWr_nxt;
            memWdata_r    <= memWdata_nxt;
            accWr_r       <= accWr_nxt;
            accWdata_r    <= accWdata_nxt;
            statusWr_r    <= statusWr_nxt;
            statusOut_r   <= statusOut_nxt;
            indexedUsed_r <= indexedUsed_nxt;
            illegal_r     <= illegal_nxt;
            done_r        <= done_nxt;
        end
    end

    // ==========================================
    // Outputs
    // All from flip-flops, so the core never sees decode glitches
    assign busy        = active_r;
    assign phase       = phaseOut_r;
    assign memAddr     = memAddr_r;
    assign memRd       = memRd_r;
    assign memWr       = memWr_r;
    assign memWdata    = memWdata_r;
    assign accWr       = accWr_r;
    assign accWdata    = accWdata_r;
    assign statusWr    = statusWr_r;
    assign statusOut   = statusOut_r;
    assign indexedUsed = indexedUsed_r;
    assign illegal     = illegal_r;
    assign done        = done_r;
endmodule // mrid_move_exec

/* File: mrid_defs.vh */
// Constants for the move-register-to-destination execution block
`ifndef MRID_DEFS_VH
`define MRID_DEFS_VH
// ==========================================
// Instruction word fields
`define MRID_OPC_HI      15
`define MRID_OPC_LO      10
`define MRID_OPC_VAL     6'h14
`define MRID_DEST_BIT    9
`define MRID_ACC_BIT     8
`define MRID_ADDR_HI     7
`define MRID_ADDR_LO     0
// ==========================================
// Reset and data values
`define MRID_RST_WORD    16'h0000
`define MRID_RST_BYTE    8'h00
`define MRID_ZERO_BYTE   8'h00
`define MRID_SIGN_BIT    7
// ==========================================
// Addressing
`define MRID_IDX_LIMIT   8'h5F
`define MRID_ACC_SPLIT   8'h80
`define MRID_ACC_HI_BANK 4'hF
`define MRID_ACC_LO_BANK 4'h0
// ==========================================
// Phases
`define MRID_Q1          2'h0
`define MRID_Q2          2'h1
`define MRID_Q3          2'h2
`define MRID_Q4          2'h3
// ==========================================
// Status flag positions
`define MRID_FLAG_Z      2
`define MRID_FLAG_N      4
`endif

/* File: mrid_addr_resolve.v */
// Operand address resolution: access bank, selected bank or indexed offset
`include "mrid_defs.vh"
module mrid_addr_resolve #(
    parameter AW = 12
) (
    input  wire [7:0]    operandAddr,
    input  wire          accessSel,
    input  wire [3:0]    bankSelect,
    input  wire          extEnable,
    input  wire [AW-1:0] indexBase,
    output reg  [AW-1:0] fullAddr,
    output reg           indexedMode
);
    always @* begin
        indexedMode = 1'b0;
        fullAddr    = {AW{1'b0}};
        if (accessSel) begin
            fullAddr = {bankSelect, operandAddr};
        end else if (extEnable && (operandAddr <= `MRID_IDX_LIMIT)) begin
            indexedMode = 1'b1;
            fullAddr    = indexBase + {{(AW-8){1'b0}}, operandAddr};
        end else if (operandAddr < `MRID_ACC_SPLIT) begin
            fullAddr = {`MRID_ACC_LO_BANK, operandAddr};
        end else begin
            fullAddr = {`MRID_ACC_HI_BANK, operandAddr};
        end
    end
endmodule // mrid_addr_resolve

/* File: mrid_move_props.sv */
// Concurrent checks on the move-register execution block ports
module mrid_move_props (
    input wire        clk,
    input wire        rst,
    input wire [15:0] instrWord,
    input wire        instrValid,
    input wire        extEnable,
    input wire [7:0]  statusIn,
    input wire        busy,
    input wire        memRd,
    input wire        memWr,
    input wire [7:0]  memWdata,
    input wire        accWr,
    input wire [7:0]  accWdata,
    input wire        statusWr,
    input wire [7:0]  statusOut,
    input wire        indexedUsed,
    input wire        illegal,
    input wire        done
);
    timeunit 1ns;
    timeprecision 100ps;
    // ==========================
    // Checks
    // The word port moves on once taken, so fields are looked at in the past
    wire [7:0]  res     = accWr ? accWdata : memWdata;
    wire        take    = instrValid && !busy;
    wire        moveOp  = instrWord[15:10] == 6'h14;
    wire        destBit = instrWord[9];
    wire        accBit  = instrWord[8];
    wire [7:0]  opField = instrWord[7:0];
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    chk_dest_select: assert property (done |-> accWr == !$past(destBit, 4)
        && memWr == $past(destBit, 4)) else $error("wrong destination");
    chk_take_read: assert property (take && moveOp |-> ##2 memRd)
        else $error("no read");
    chk_bad_opcode: assert property (take && !moveOp |=> illegal && !memRd)
        else $error("bad opcode not refused");
    chk_read_write: assert property (memRd |-> ##2 done)
        else $error("write late");
    chk_done_once: assert property (done |=> !done && !accWr && !memWr)
        else $error("write repeated");
    chk_flags_only: assert property (statusWr |-> ((statusOut & 8'hEB)
        == ($past(statusIn) & 8'hEB)) && statusOut[4] == res[7]
        && statusOut[2] == (res == 8'h00)) else $error("status wrong");
    chk_flags_each: assert property (done |-> statusWr)
        else $error("status not written");
    chk_index_cond: assert property (memRd |-> indexedUsed == ($past(extEnable)
        && !$past(accBit, 2) && $past(opField, 2) <= 8'h5F)) else $error("indexed wrongly");
    cover property (accWr);
    cover property (memWr);
    cover property (memRd && indexedUsed);
    cover property (illegal);
endmodule // mrid_move_props
bind mrid_move_exec mrid_move_props mrid_move_props_i (
    .clk         (clk),
    .rst         (rst),
    .instrWord   (instrWord),
    .instrValid  (instrValid),
    .extEnable   (extEnable),
    .statusIn    (statusIn),
    .busy        (busy),
    .memRd       (memRd),
    .memWr       (memWr),
    .memWdata    (memWdata),
    .accWr       (accWr),
    .accWdata    (accWdata),
    .statusWr    (statusWr),
    .statusOut   (statusOut),
    .indexedUsed (indexedUsed),
    .illegal     (illegal),
    .done        (done)
);

/* File: tb.sv */
// Self-checking bench for the move-register execution block
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    reg         clk        = 1'b0;
    reg         rst        = 1'b1;
    reg         instrValid = 1'b0;
    reg         extEnable  = 1'b1;
    reg         hung       = 1'b0;
    reg  [15:0] instrWord  = 16'h0000;
    reg  [3:0]  bankSelect = 4'h5;
    reg  [11:0] indexBase  = 12'h3A0;
    reg  [7:0]  memRdata   = 8'h00;
    reg  [7:0]  statusIn   = 8'hFF;
    reg  [31:0] r;
    wire [11:0] memAddr;
    wire [7:0]  memWdata;
    wire [7:0]  accWdata;
    wire [7:0]  statusOut;
    wire [1:0]  phase;
    wire        busy;
    wire        memRd;
    wire        memWr;
    wire        accWr;
    wire        statusWr;
    wire        indexedUsed;
    wire        illegal;
    wire        done;
    integer     n_mismatch = 0;
    integer     compares   = 0;
    integer     seed       = 9318;
    integer     i;
    always #2.5 clk = ~clk;
    mrid_move_exec #(
        .AW (12)
    ) mrid_move_exec_i (
        .clk         (clk),
        .rst         (rst),
        .instrWord   (instrWord),
        .instrValid  (instrValid),
        .bankSelect  (bankSelect),
        .extEnable   (extEnable),
        .indexBase   (indexBase),
        .memRdata    (memRdata),
        .statusIn    (statusIn),
        .phase       (phase),
        .busy        (busy),
        .memAddr     (memAddr),
        .memRd       (memRd),
        .memWr       (memWr),
        .memWdata    (memWdata),
        .accWr       (accWr),
        .accWdata    (accWdata),
        .statusWr    (statusWr),
        .statusOut   (statusOut),
        .indexedUsed (indexedUsed),
        .illegal     (illegal),
        .done        (done)
    );
    // ==========================
    // Checking helpers
    task chk(input [8*8:1] nm, input [11:0] e, input [11:0] g);
        begin
            compares = compares + 1;
            if (g !== e) begin
                n_mismatch = n_mismatch + 1;
                $display("BAD %0s exp %h got %h", nm, e, g);
            end
        end
    endtask
    function [11:0] expAddr(input [15:0] w);
        if (w[8]) expAddr = {bankSelect, w[7:0]};
        else if (extEnable && w[7:0] <= 8'h5F) expAddr = indexBase + w[7:0];
        else expAddr = {w[7] ? 4'hF : 4'h0, w[7:0]};
    endfunction
    function expIdx(input [15:0] w);
        expIdx = !w[8] && extEnable && (w[7:0] <= 8'h5F);
    endfunction
    function [7:0] expStat(input [7:0] v);
        expStat = {statusIn[7:5], v[7], statusIn[3], v == 8'h00, statusIn[1:0]};
    endfunction
    // Once a wait runs out, later calls do nothing so the report is reached
    task go(input [15:0] w, input [7:0] v);
        integer k;
        begin
            if (!hung) begin
                instrWord  = w;
                instrValid = 1'b1;
                memRdata   = v;
                @(posedge clk);
                #1 instrValid = 1'b0;
                for (k = 0; k < 8 && done !== 1'b1 && illegal !== 1'b1; k = k + 1) begin
                    if (memRd === 1'b1) begin
                        chk("addr", expAddr(w), memAddr);
                        chk("index", expIdx(w), indexedUsed);
                        chk("busy", 12'h001, busy);
                        chk("phase", 12'h001, phase);
                    end
                    @(posedge clk);
                    #1;
                end
                if (k == 8) begin
                    chk("time", 12'h001, 12'h000);
                    hung = 1'b1;
                end else if (w[15:10] != 6'h14) begin
                    chk("illegal", 12'h001, illegal);
                    chk("done", 12'h000, done);
                    chk("read", 12'h000, memRd);
                    @(posedge clk);
                    #1;
                end else begin
                    chk("data", v, w[9] ? memWdata : accWdata);
                    chk("dest", {w[9], !w[9]}, {memWr, accWr});
                    chk("stat", expStat(v), statusOut);
                    chk("flagwr", 12'h001, statusWr);
                    chk("steps", 12'h003, k[11:0]);
                    chk("phase", 12'h003, phase);
                    chk("busy", 12'h000, busy);
                end
                $display("test %h ended", w);
            end
        end
    endtask
    task test_done;
        begin
            $display("compares %0d mismatches %0d", compares, n_mismatch);
            if (n_mismatch == 0 && compares > 0) $display("SIMULATION PASSED");
            else $display("SIMULATION FAILED");
            $finish;
        end
    endtask
    // ==========================
    // Sequence
    initial begin
        repeat (5) @(posedge clk);
        #1 rst = 1'b0;
        go(16'h505F, 8'h00);
        go(16'h5060, 8'h80);
        go(16'h5080, 8'h7F);
        go(16'h53FF, 8'h01);
        go(16'h4C00, 8'h55);
        // Reset in the middle of an instruction drops it
        instrWord  = 16'h5100;
        instrValid = 1'b1;
        @(posedge clk);
        #1 instrValid = 1'b0;
        chk("busy", 12'h001, busy);
        rst = 1'b1;
        @(posedge clk);
        #1 rst = 1'b0;
        chk("busy", 12'h000, busy);
        chk("read", 12'h000, memRd);
        for (i = 0; i < 60; i = i + 1) begin
            r          = $random(seed);
            bankSelect = r[3:0];
            extEnable  = r[4];
            statusIn   = r[12:5];
            indexBase  = r[24:13];
            r          = $random(seed);
            go({(r[31] | r[30]) ? 6'h14 : r[29:24], r[9:0]}, r[17:10]);
        end
        test_done;
    end
endmodule // tb
